// ### hw/cdbu_pkg.sv
package cdbu_pkg;
  // ==========================================================
  // Sizes
  localparam int          NUM_BP       = 4;
  localparam int          NUM_THREADS  = 8;
  localparam int          NUM_SCRATCH  = 8;
  localparam int          NUM_EVT      = 5;
  localparam int          ADDR_W       = 12;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0]  IDX_SSR      = 8'h10;
  localparam logic [7:0]  IDX_SPC      = 8'h11;
  localparam logic [7:0]  IDX_SSP      = 8'h12;
  localparam logic [7:0]  IDX_GR_THR   = 8'h13;
  localparam logic [7:0]  IDX_GR_REG   = 8'h14;
  localparam logic [7:0]  IDX_CAUSE    = 8'h15;
  localparam logic [7:0]  IDX_PAYLOAD  = 8'h16;
  localparam logic [7:0]  IDX_STOP     = 8'h18;
  localparam logic [7:0]  IDX_SCRATCH  = 8'h20;
  localparam logic [7:0]  IDX_BP_ADDR  = 8'h30;
  localparam logic [7:0]  IDX_BP_CTRL  = 8'h40;
  localparam logic [7:0]  IDX_EVT_STAT = 8'ha0;
  localparam logic [7:0]  IDX_EVT_CLR  = 8'ha1;
  localparam logic [7:0]  IDX_EVT_EN   = 8'ha2;
  // ==========================================================
  // Field layouts
  localparam logic [31:0] SSR_WR_MASK  = 32'h0000_06df;
  localparam int          SSR_ISS_CUR  = 8;
  localparam int          SSR_ISS_KERN = 9;
  localparam logic [31:0] GR_THR_MASK  = 32'h0000_00ff;
  localparam logic [31:0] GR_REG_MASK  = 32'h0000_001f;
  localparam logic [31:0] CAUSE_MASK   = 32'h0003_ff07;
  localparam logic [31:0] STOP_MASK    = 32'h0000_00ff;
  localparam logic [31:0] BP_CTRL_MASK = 32'h00ff_0003;
  localparam logic [31:0] EVT_MASK     = 32'h0000_001f;
  localparam int          BP_EN_BIT    = 0;
  localparam int          BP_NE_BIT    = 1;
  localparam int          BP_THR_LSB   = 16;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  // ==========================================================
  // Cause codes and event bits
  localparam logic [2:0]  CAUSE_HOST   = 3'h1;
  localparam logic [2:0]  CAUSE_DEBUG_CALL_INSTR  = 3'h2;
  localparam logic [2:0]  CAUSE_IBREAK = 3'h3;
  localparam logic [2:0]  CAUSE_DWATCH = 3'h4;
  localparam logic [2:0]  CAUSE_RWATCH = 3'h5;
  localparam int          EVT_HOST     = 0;
  localparam int          EVT_DEBUG_CALL_INSTR    = 1;
  localparam int          EVT_IBREAK   = 2;
  localparam int          EVT_DWATCH   = 3;
  localparam int          EVT_RWATCH   = 4;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] pc;
    logic [31:0] sp;
  } cdbu_entry_t;
  typedef struct packed {
    logic [7:0]  thread;
    logic [1:0]  index;
    logic [31:0] data;
  } cdbu_watch_t;
endpackage

// ### hw/cdbu_top.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module cdbu_top
  import cdbu_pkg::*;
#(
  parameter int N_BP      = NUM_BP,
  parameter int N_THREADS = NUM_THREADS
) (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ADDR_W-1:0]            paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         entry_valid,
  input  wire cdbu_entry_t                  entry,
  input  wire logic                         cur_issue_mode,
  input  wire logic                         debug_mode,
  input  wire logic                         host_req,
  input  wire logic                         debug_call_instr_req,
  input  wire logic [7:0]                   debug_call_instr_thread,
  input  wire logic                         dwatch_hit,
  input  wire cdbu_watch_t                  dwatch,
  input  wire logic                         rwatch_hit,
  input  wire cdbu_watch_t                  rwatch,
  input  wire logic                         issue_valid,
  input  wire logic [$clog2(N_THREADS)-1:0] issue_thread,
  input  wire logic [31:0]                  issue_pc,
  input  wire logic                         cfg_sel,
  input  wire logic                         cfg_write,
  input  wire logic [2:0]                   cfg_idx,
  input  wire logic [31:0]                  cfg_wdata,
  output logic      [31:0]                  cfg_rdata,
  output logic                              dbg_int_req,
  output logic      [7:0]                   thread_stop,
  output logic                              kernel_issue_mode,
  output logic      [7:0]                   getreg_thread,
  output logic      [4:0]                   getreg_index,
  output logic                              irq
);
  // ==========================================================
  // Elaboration checks
  if (N_BP < 1 || N_BP > 4) begin : g_bp_chk
    $error("N_BP must be 1 to 4");
  end
  if (N_THREADS < 2 || N_THREADS > 8) begin : g_thr_chk
    $error("N_THREADS must be 2 to 8");
  end

  // ==========================================================
  // Registers
  logic [31:0]  ssr_reg;
  logic [31:0]  spc_reg;
  logic [31:0]  ssp_reg;
  logic [31:0]  gr_thr_reg;
  logic [31:0]  gr_reg_reg;
  logic [31:0]  cause_reg;
  logic [31:0]  payload_reg;
  logic [31:0]  stop_reg;
  logic [31:0]  scratch_reg [NUM_SCRATCH];
  logic [31:0]  bp_addr_reg [N_BP];
  logic [31:0]  bp_ctrl_reg [N_BP];
  logic [31:0]  evt_stat_reg;
  logic [31:0]  evt_en_reg;
  logic [31:0]  prdata_reg;
  logic [31:0]  cfg_rdata_reg;
  logic         dbg_int_reg;
  logic [7:0]   stop_out_reg;

  // ==========================================================
  // APB decode
  logic [7:0]   idx;
  logic         addr_ok;
  logic         acc;
  logic         wr;
  logic         mapped;
  logic         h_scr;
  logic         h_bpa;
  logic         h_bpc;
  logic [31:0]  bmask;
  logic [31:0]  rd_mux;

  assign idx     = paddr[9:2];
  assign addr_ok = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
  assign acc     = psel && penable;
  assign h_scr   = idx[7:3] == IDX_SCRATCH[7:3];
  assign h_bpa   = (idx[7:2] == IDX_BP_ADDR[7:2]) && (32'(idx[1:0]) < N_BP);
  assign h_bpc   = (idx[7:2] == IDX_BP_CTRL[7:2]) && (32'(idx[1:0]) < N_BP);
  assign bmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    mapped = h_scr || h_bpa || h_bpc;
    case (idx)
      IDX_SSR, IDX_SPC, IDX_SSP, IDX_GR_THR, IDX_GR_REG, IDX_CAUSE,
      IDX_PAYLOAD, IDX_STOP, IDX_EVT_STAT, IDX_EVT_CLR,
      IDX_EVT_EN: mapped = 1'b1;
      default:    ;
    endcase
    mapped = mapped && addr_ok;
  end

  assign wr = acc && pwrite && mapped;

  // Byte lanes and field mask both gate a write
  function automatic logic [31:0] upd(input logic [31:0] old, input logic [31:0] keep);
    upd = (old & ~(bmask & keep)) | (pwdata & bmask & keep);
  endfunction

  function automatic logic [31:0] mk_cause(input logic [2:0] code, input logic [7:0] thr,
                                           input logic [1:0] ix);
    mk_cause = {14'h0000, ix, thr, 5'h00, code};
  endfunction

  always_comb begin
    rd_mux = RST_ZERO;
    if (h_scr) begin
      rd_mux = scratch_reg[idx[2:0]];
    end else if (h_bpa) begin
      rd_mux = bp_addr_reg[idx[1:0]];
    end else if (h_bpc) begin
      rd_mux = bp_ctrl_reg[idx[1:0]];
    end else begin
      case (idx)
        IDX_SSR:      rd_mux = (ssr_reg & SSR_WR_MASK) | (32'(cur_issue_mode) << SSR_ISS_CUR);
        IDX_SPC:      rd_mux = spc_reg;
        IDX_SSP:      rd_mux = ssp_reg;
        IDX_GR_THR:   rd_mux = gr_thr_reg;
        IDX_GR_REG:   rd_mux = gr_reg_reg;
        IDX_CAUSE:    rd_mux = cause_reg;
        IDX_PAYLOAD:  rd_mux = payload_reg;
        IDX_STOP:     rd_mux = stop_reg;
        IDX_EVT_STAT: rd_mux = evt_stat_reg;
        IDX_EVT_EN:   rd_mux = evt_en_reg;
        default:      rd_mux = RST_ZERO;
      endcase
    end
    if (!addr_ok) begin
      rd_mux = RST_ZERO;
    end
  end

  // Read data is caught in the setup cycle so the access needs no wait state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_reg <= RST_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // ==========================================================
  // Breakpoint match
  logic [N_BP-1:0] bp_hit;
  logic [1:0]      bp_low;
  logic            ev_bp;

  for (genvar i = 0; i < N_BP; i++) begin : g_bp
    logic same;
    assign same = issue_pc == bp_addr_reg[i];
    assign bp_hit[i] = issue_valid && !debug_mode
                     && bp_ctrl_reg[i][BP_EN_BIT]
                     && bp_ctrl_reg[i][BP_THR_LSB + 32'(issue_thread)]
                     && (bp_ctrl_reg[i][BP_NE_BIT] ? !same : same);
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        bp_addr_reg[i] <= RST_ZERO;
        bp_ctrl_reg[i] <= RST_ZERO;
      end else if (wr && h_bpa && idx[1:0] == 2'(i)) begin
        bp_addr_reg[i] <= upd(bp_addr_reg[i], 32'hffff_ffff);
      end else if (wr && h_bpc && idx[1:0] == 2'(i)) begin
        bp_ctrl_reg[i] <= upd(bp_ctrl_reg[i], BP_CTRL_MASK);
      end
    end
  end

  always_comb begin
    bp_low = 2'b00;
    for (int j = N_BP - 1; j >= 0; j--) begin
      if (bp_hit[j]) begin
        bp_low = 2'(j);
      end
    end
  end

  assign ev_bp = |bp_hit;

  // ==========================================================
  // Debug entry capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ssr_reg <= RST_ZERO;
      spc_reg <= RST_ZERO;
      ssp_reg <= RST_ZERO;
    end else if (entry_valid) begin
      ssr_reg <= entry.status & SSR_WR_MASK;
      spc_reg <= entry.pc;
      ssp_reg <= entry.sp;
    end else if (wr) begin
      if (idx == IDX_SSR) begin
        ssr_reg <= upd(ssr_reg, SSR_WR_MASK);
      end
      if (idx == IDX_SPC) begin
        spc_reg <= upd(spc_reg, 32'hffff_ffff);
      end
      if (idx == IDX_SSP) begin
        ssp_reg <= upd(ssp_reg, 32'hffff_ffff);
      end
    end
  end

  assign kernel_issue_mode = ssr_reg[SSR_ISS_KERN];

  // ==========================================================
  // Get-register operands and stop vector
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gr_thr_reg <= RST_ZERO;
      gr_reg_reg <= RST_ZERO;
      stop_reg   <= RST_ZERO;
    end else if (wr) begin
      if (idx == IDX_GR_THR) begin
        gr_thr_reg <= upd(gr_thr_reg, GR_THR_MASK);
      end
      if (idx == IDX_GR_REG) begin
        gr_reg_reg <= upd(gr_reg_reg, GR_REG_MASK);
      end
      if (idx == IDX_STOP) begin
        stop_reg <= upd(stop_reg, STOP_MASK);
      end
    end
  end

  assign getreg_thread = gr_thr_reg[7:0];
  assign getreg_index  = gr_reg_reg[4:0];

  // Stop is released while in debug mode so the handler itself can run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stop_out_reg <= 8'h00;
    end else begin
      stop_out_reg <= debug_mode ? 8'h00 : stop_reg[7:0];
    end
  end

  assign thread_stop = stop_out_reg;

  // ==========================================================
  // Cause, thread, index and payload recording
  logic [NUM_EVT-1:0] ev_vec;
  logic               ev_any;

  assign ev_vec = {rwatch_hit, dwatch_hit, ev_bp, debug_call_instr_req, host_req};
  assign ev_any = |ev_vec;

  // One cause per cycle: breakpoint, data, resource, call, host
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause_reg <= RST_ZERO;
    end else if (ev_bp) begin
      cause_reg <= mk_cause(CAUSE_IBREAK, 8'(issue_thread), bp_low);
    end else if (dwatch_hit) begin
      cause_reg <= mk_cause(CAUSE_DWATCH, dwatch.thread, dwatch.index);
    end else if (rwatch_hit) begin
      cause_reg <= mk_cause(CAUSE_RWATCH, rwatch.thread, rwatch.index);
    end else if (debug_call_instr_req) begin
      cause_reg <= mk_cause(CAUSE_DEBUG_CALL_INSTR, debug_call_instr_thread, 2'b00);
    end else if (host_req) begin
      cause_reg <= mk_cause(CAUSE_HOST, 8'h00, 2'b00);
    end else if (wr && idx == IDX_CAUSE) begin
      cause_reg <= upd(cause_reg, CAUSE_MASK);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      payload_reg <= RST_ZERO;
    end else if (!ev_bp && dwatch_hit) begin
      payload_reg <= dwatch.data;
    end else if (!ev_bp && rwatch_hit) begin
      payload_reg <= rwatch.data;
    end else if (wr && idx == IDX_PAYLOAD) begin
      payload_reg <= upd(payload_reg, 32'hffff_ffff);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dbg_int_reg <= 1'b0;
    end else begin
      dbg_int_reg <= ev_any;
    end
  end

  assign dbg_int_req = dbg_int_reg;

  // ==========================================================
  // Scratch words, APB wins over the configuration path
  for (genvar k = 0; k < NUM_SCRATCH; k++) begin : g_scr
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        scratch_reg[k] <= RST_ZERO;
      end else if (wr && h_scr && idx[2:0] == 3'(k)) begin
        scratch_reg[k] <= upd(scratch_reg[k], 32'hffff_ffff);
      end else if (cfg_sel && cfg_write && cfg_idx == 3'(k)) begin
        scratch_reg[k] <= cfg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata_reg <= RST_ZERO;
    end else if (cfg_sel && !cfg_write) begin
      cfg_rdata_reg <= scratch_reg[cfg_idx];
    end
  end

  assign cfg_rdata = cfg_rdata_reg;

  // ==========================================================
  // Event status, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_stat_reg <= RST_ZERO;
      evt_en_reg   <= RST_ZERO;
    end else begin
      if (wr && idx == IDX_EVT_CLR) begin
        evt_stat_reg <= (evt_stat_reg & ~(pwdata & bmask & EVT_MASK)) | 32'(ev_vec);
      end else begin
        evt_stat_reg <= evt_stat_reg | 32'(ev_vec);
      end
      if (wr && idx == IDX_EVT_EN) begin
        evt_en_reg <= upd(evt_en_reg, EVT_MASK);
      end
    end
  end

  assign irq = |(evt_stat_reg & evt_en_reg);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  entry_capture_a: assert property (entry_valid |=> spc_reg == $past(entry.pc)
      && ssp_reg == $past(entry.sp) && ssr_reg == ($past(entry.status) & SSR_WR_MASK))
    else $error("debug entry not captured");
  ssr_readback_a: assert property (psel && !penable && !pwrite && addr_ok && idx == IDX_SSR
      |=> prdata[SSR_ISS_CUR] == $past(cur_issue_mode) && prdata[5] == 1'b0)
    else $error("saved status read bits wrong");
  bp_cause_a: assert property (ev_bp |=> cause_reg[2:0] == CAUSE_IBREAK
      && cause_reg[17:16] == $past(bp_low) && dbg_int_req)
    else $error("breakpoint cause not recorded");
  bp_lowest_a: assert property (bp_hit[0] |=> cause_reg[17:16] == 2'b00)
    else $error("lowest breakpoint not reported");
  host_zero_a: assert property (host_req && !(|ev_vec[NUM_EVT-1:1])
      |=> cause_reg == 32'(CAUSE_HOST))
    else $error("host cause fields not zero");
  dwatch_data_a: assert property (dwatch_hit && !ev_bp |=> payload_reg == $past(dwatch.data)
      && cause_reg[2:0] == CAUSE_DWATCH)
    else $error("watch payload not stored");
  stop_vec_a: assert property (##1 thread_stop == ($past(debug_mode) ? 8'h00
      : $past(stop_reg[7:0])))
    else $error("stop vector wrong");
  bp_gate_a: assert property (bp_hit[0] |-> bp_ctrl_reg[0][BP_EN_BIT]
      && bp_ctrl_reg[0][BP_THR_LSB + 32'(issue_thread)] && !debug_mode)
    else $error("breakpoint fired while disabled");
  reserved_a: assert property (psel && !penable && !pwrite && addr_ok && idx == IDX_GR_REG
      |=> prdata[31:5] == 27'h0)
    else $error("reserved bits read nonzero");
  irq_level_a: assert property (ev_vec[EVT_IBREAK] |=> evt_stat_reg[EVT_IBREAK]
      && (irq || !evt_en_reg[EVT_IBREAK]))
    else $error("interrupt status not set");
endmodule

// ### testbench/cdbu_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Thread pipeline model: round-robin issue, one thread a cycle
module cdbu_core_model
  import cdbu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic [31:0] base_pc,
  input  wire logic [7:0]  thread_stop,
  output logic             issue_valid,
  output logic      [2:0]  issue_thread,
  output logic      [31:0] issue_pc
);
  logic [2:0]  thr_reg;
  logic [31:0] pc_next;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      thr_reg <= 3'h0;
    end else begin
      thr_reg <= thr_reg + 3'h1;
    end
  end
  // Each thread sits at its own fixed pc, four bytes apart
  assign pc_next      = base_pc + {27'h0, thr_reg, 2'h0};
  // A stopped thread takes no issue slot
  assign issue_valid  = run && !thread_stop[thr_reg];
  assign issue_thread = thr_reg;
  // Idle slots show a changing pattern, never a stale pc
  assign issue_pc     = issue_valid ? pc_next : ~pc_next;
endmodule

// ### testbench/test_core_debug_breakpoint_unit.sv
`timescale 1ns/1ps
module test_core_debug_breakpoint_unit;
  import cdbu_pkg::*;
  // ==========================================================
  // Signals
  logic              clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, issue_pc, cfg_wdata, cfg_rdata, base_pc;
  logic [3:0]        pstrb;
  logic              entry_valid, cur_issue_mode, debug_mode, host_req, debug_call_instr_req;
  logic              dwatch_hit, rwatch_hit, issue_valid, run, cfg_sel, cfg_write;
  logic              dbg_int_req, kernel_issue_mode, irq;
  logic [7:0]        debug_call_instr_thread, thread_stop, getreg_thread;
  logic [4:0]        getreg_index;
  logic [2:0]        issue_thread, cfg_idx;
  cdbu_entry_t       entry;
  cdbu_watch_t       dwatch, rwatch;
  int                n_errors, checks_done, i;
  logic [31:0]       ev_cause [4];
  logic [31:0]       ev_data  [4];
  logic [31:0]       r;
  logic              e;
  cdbu_top u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .entry_valid(entry_valid), .entry(entry),
    .cur_issue_mode(cur_issue_mode), .debug_mode(debug_mode), .host_req(host_req),
    .debug_call_instr_req(debug_call_instr_req), .debug_call_instr_thread(debug_call_instr_thread), .dwatch_hit(dwatch_hit),
    .dwatch(dwatch), .rwatch_hit(rwatch_hit), .rwatch(rwatch), .issue_valid(issue_valid),
    .issue_thread(issue_thread), .issue_pc(issue_pc), .cfg_sel(cfg_sel),
    .cfg_write(cfg_write), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .dbg_int_req(dbg_int_req), .thread_stop(thread_stop),
    .kernel_issue_mode(kernel_issue_mode), .getreg_thread(getreg_thread),
    .getreg_index(getreg_index), .irq(irq));
  cdbu_core_model u_core (.clk(clk), .resetn(resetn), .run(run), .base_pc(base_pc),
    .thread_stop(thread_stop), .issue_valid(issue_valid), .issue_thread(issue_thread),
    .issue_pc(issue_pc));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] sb, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    pstrb   <= sb;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // The slave may stretch the access phase; the loop waits for pready with no limit of its own but the watchdog
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] sb = 4'hf);
    logic [31:0] rr;
    logic        ee;
    apb(1'b1, idx, d, sb, rr, ee);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rr;
    logic        ee;
    apb(1'b0, idx, 32'h0, 4'hf, rr, ee);
    chk(rr, exp);
  endtask
  task automatic evt(input int k);
    @(posedge clk);
    host_req   <= (k == 0);
    debug_call_instr_req  <= (k == 1);
    dwatch_hit <= (k == 2);
    rwatch_hit <= (k == 3);
    @(posedge clk);
    {host_req, debug_call_instr_req, dwatch_hit, rwatch_hit} <= 4'h0;
    @(negedge clk);
    chk({31'h0, dbg_int_req}, 32'h1);
    @(negedge clk);
    chk({31'h0, dbg_int_req}, 32'h0);
  endtask
  task automatic cfg_rd(input int k, input logic [31:0] exp);
    @(posedge clk);
    cfg_sel   <= 1'b1;
    cfg_write <= 1'b0;
    cfg_idx   <= 3'(k);
    @(posedge clk);
    cfg_sel   <= 1'b0;
    @(negedge clk);
    chk(cfg_rdata, exp);
  endtask
  // Clears the cause, lets the core run, then reads what was recorded
  task automatic run_core(input logic [31:0] exp);
    wr(IDX_CAUSE, 32'h0);
    @(posedge clk);
    run <= 1'b1;
    repeat (12) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(IDX_CAUSE, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up;
  end
  initial begin
    {psel, penable, pwrite, entry_valid, debug_mode, host_req, debug_call_instr_req} = '0;
    {dwatch_hit, rwatch_hit, run, cfg_sel, cfg_write} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    cfg_idx = '0;
    cfg_wdata = '0;
    cur_issue_mode = 1'b1;
    debug_call_instr_thread = 8'h05;
    base_pc = 32'h0000_1000;
    entry = '{32'hffff_ffff, 32'h8000_0004, 32'h0001_fff0};
    dwatch = '{8'h03, 2'h2, 32'h2000_0040};
    rwatch = '{8'h06, 2'h1, 32'h0000_0c02};
    ev_cause = '{32'h0000_0001, 32'h0000_0502, 32'h0002_0304, 32'h0001_0605};
    ev_data = '{32'h0, 32'h0, 32'h2000_0040, 32'h0000_0c02};
    n_errors = 0;
    checks_done = 0;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(IDX_CAUSE, RST_ZERO);
    for (i = 0; i < 4; i++) rd_chk(8'(IDX_BP_CTRL + i), RST_ZERO);
    @(posedge clk);
    entry_valid <= 1'b1;
    @(posedge clk);
    entry_valid <= 1'b0;
    rd_chk(IDX_SSR, 32'h0000_07df);
    rd_chk(IDX_SPC, 32'h8000_0004);
    rd_chk(IDX_SSP, 32'h0001_fff0);
    chk({31'h0, kernel_issue_mode}, 32'h1);
    cur_issue_mode <= 1'b0;
    wr(IDX_SSR, 32'hffff_fdff);
    rd_chk(IDX_SSR, 32'h0000_04df);
    chk({31'h0, kernel_issue_mode}, 32'h0);
    wr(IDX_GR_THR, 32'hffff_ffa5);
    wr(IDX_GR_REG, 32'hffff_ffff);
    rd_chk(IDX_GR_THR, 32'h0000_00a5);
    rd_chk(IDX_GR_REG, 32'h0000_001f);
    chk({19'h0, getreg_index, getreg_thread}, 32'h0000_1fa5);
    wr(IDX_STOP, 32'hffff_ff04);
    rd_chk(IDX_STOP, 32'h0000_0004);
    repeat (2) @(negedge clk);
    chk({24'h0, thread_stop}, 32'h0000_0004);
    @(posedge clk);
    debug_mode <= 1'b1;
    repeat (2) @(negedge clk);
    chk({24'h0, thread_stop}, 32'h0);
    @(posedge clk);
    debug_mode <= 1'b0;
    for (i = 0; i < 8; i++) wr(8'(IDX_SCRATCH + i), 32'h5a00_0000 | i);
    for (i = 0; i < 8; i++) cfg_rd(i, 32'h5a00_0000 | i);
    @(posedge clk);
    cfg_sel   <= 1'b1;
    cfg_write <= 1'b1;
    cfg_idx   <= 3'h3;
    cfg_wdata <= 32'hc0de_0003;
    @(posedge clk);
    cfg_sel   <= 1'b0;
    cfg_write <= 1'b0;
    rd_chk(8'(IDX_SCRATCH + 3), 32'hc0de_0003);
    wr(IDX_SCRATCH, 32'h0000_00ff, 4'h1);
    rd_chk(IDX_SCRATCH, 32'h5a00_00ff);
    for (i = 0; i < 4; i++) begin
      evt(i);
      rd_chk(IDX_CAUSE, ev_cause[i]);
      rd_chk(IDX_PAYLOAD, ev_data[i]);
    end
    rd_chk(IDX_EVT_STAT, 32'h0000_001b);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_EVT_EN, 32'h0000_0001);
    // The enable lands at this edge, so look once it has settled
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_EVT_EN, 32'h0);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_EVT_CLR, 32'h0000_001b);
    rd_chk(IDX_EVT_STAT, 32'h0);
    apb(1'b0, 8'h17, 32'h0, 4'hf, r, e);
    chk({r[30:0], e}, 32'h1);
    // Thread 2 is still stopped, so its breakpoint cannot be reached yet
    wr(IDX_BP_ADDR, 32'h0000_1008);
    wr(IDX_BP_CTRL, 32'hff04_fff1);
    rd_chk(IDX_BP_CTRL, 32'h0004_0001);
    run_core(32'h0);
    wr(IDX_STOP, 32'h0);
    run_core(32'h0000_0203);
    for (i = 0; i < 4; i++) wr(8'(IDX_BP_ADDR + i), 32'h0000_1014);
    for (i = 0; i < 4; i++) rd_chk(8'(IDX_BP_ADDR + i), 32'h0000_1014);
    wr(IDX_BP_CTRL, 32'h0020_0000);
    wr(8'(IDX_BP_CTRL + 1), 32'h0020_0001);
    wr(8'(IDX_BP_CTRL + 3), 32'h0020_0001);
    run_core(32'h0001_0503);
    wr(8'(IDX_BP_CTRL + 1), 32'h0);
    wr(8'(IDX_BP_CTRL + 3), 32'h0);
    wr(8'(IDX_BP_CTRL + 2), 32'h0020_0003);
    run_core(32'h0);
    wr(8'(IDX_BP_CTRL + 2), 32'h0040_0003);
    run_core(32'h0002_0603);
    wr(8'(IDX_BP_CTRL + 2), 32'h0000_0003);
    run_core(32'h0);
    wrap_up;
  end
endmodule
